// ---- shared/boot_erase_params.svh ----
`ifndef BOOT_ERASE_PARAMS_SVH
`define BOOT_ERASE_PARAMS_SVH
// Command and answer codes
`define CMD_CHIP_ERASE 8'h40
`define CMD_ERASE_ENABLE 8'h54
`define ACK_NORMAL 8'h40
`define ACK_ABNORMAL 8'h41
`define ACK_COMM_ERR 8'h48
`define ACK_ENABLE_COMM_ERR 8'h58
`define NIB_CMD_ERR 4'h1
`define NIB_COMM_ERR 4'h8
`define ACK_ERASE_DONE 8'h4f
`define ACK_ERASE_FAIL 8'h4c
// Password layout
`define PWD_BYTES 4'hc
`define PWD_LAST_IDX 4'hb
`define PWD_TOP_ADDR 32'h3f81ffff
`define PWD_FIRST_ADDR 32'h3f81fff4
// Host-side settle time after a negative erase result
`define ERASE_RECHECK_US 200
`define CLK_MHZ 20
`define ERASE_RECHECK_CYC ((`ERASE_RECHECK_US) * (`CLK_MHZ))
`endif

// ---- shared/boot_erase_pkg.sv ----
package boot_erase_pkg;
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_PWD = 3'b001,
    ST_SUM = 3'b010,
    ST_ENA = 3'b011,
    ST_ERASE = 3'b100
  } state_t;
endpackage

// ---- hw/boot_chip_erase_protocol.sv ----
`timescale 1ns/1ps
`include "boot_erase_params.svh"
// Behaviour
// - UART receive error on command byte answers low nibble 8.
// - Command-byte errors and wrong enable bytes carry upper nibble of last command byte.
// - Clocked serial mode never reports receive errors.
// - Supported command byte is echoed back.
// - Unsupported command answers low nibble 1, waits for command.
// - Password bytes compared in order with stored bytes; mismatch sets flag.
// - UART receive error in bytes two to fourteen answers 0x48 when a password is required.
// - Wrong checksum answers 0x41 and returns to command wait.
// - Password error flag answers 0x41 and returns to command wait.
// - No password needed or all checks pass answers 0x40.
// - Receive error on byte fifteen answers 0x58.
// - Matching erase enable is echoed and erase starts in the same cycle.
// - Wrong enable byte answers low nibble 1 with previous upper nibble.
// - Erase end sends 0x4f on success, 0x4c on failure.
// - After result byte, wait for next operation command.
module boot_chip_erase_protocol
  import boot_erase_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic uartMode,
  input wire logic pwdRequired,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxError,
  output logic [3:0] pwdIndex,
  input wire logic [7:0] pwdStored,
  input wire logic [7:0] sumCalc,
  output logic sumClear,
  output logic txValid,
  output logic [7:0] txData,
  output logic eraseStart,
  input wire logic eraseDone,
  input wire logic eraseFail
);

  // ----------------------------------------
  // Mode pin synchronisers
  // ----------------------------------------
  logic uartMeta, uartSync, pwdMeta, pwdSync;
  logic next_uartMeta, next_pwdMeta;

  // Pins from outside pass two flops
  always_comb begin
    next_uartMeta = uartMode;
    next_pwdMeta = pwdRequired;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      uartMeta <= 1'b0;
      uartSync <= 1'b0;
      pwdMeta <= 1'b0;
      pwdSync <= 1'b0;
    end else begin
      uartMeta <= next_uartMeta;
      uartSync <= uartMeta;
      pwdMeta <= next_pwdMeta;
      pwdSync <= pwdMeta;
    end
  end

  // ----------------------------------------
  // Byte decode shared by all groups
  // ----------------------------------------
  state_t state, next_state;
  logic [3:0] next_pwdIndex;
  logic [3:0] lastNibble, next_lastNibble;
  logic pwdErr, next_pwdErr;
  logic rxErrSeen, next_rxErrSeen;
  logic next_sumClear;
  logic next_txValid, next_eraseStart;
  logic [7:0] next_txData;
  logic rxErrUart;
  logic cmdMatch;
  logic enableMatch;
  logic pwdLast;
  logic sumErrs;
  logic sumPass;

  assign rxErrUart = rxError & uartSync;
  assign cmdMatch = (rxData == `CMD_CHIP_ERASE);
  assign enableMatch = (rxData == `CMD_ERASE_ENABLE);
  assign pwdLast = (pwdIndex == `PWD_LAST_IDX);
  // Errors so far or on this byte
  assign sumErrs = rxErrSeen | rxErrUart;
  assign sumPass = !pwdSync | (!sumErrs & (rxData == sumCalc) & !pwdErr);

  // ----------------------------------------
  // Sequence state
  // ----------------------------------------
  // Next step of the byte sequence
  always_comb begin
    next_state = state;
    case (state)
      ST_CMD: begin
        if (rxValid && !rxErrUart && cmdMatch) begin
          next_state = ST_PWD;
        end
      end
      ST_PWD: begin
        // Twelve bytes, no answer
        if (rxValid && pwdLast) begin
          next_state = ST_SUM;
        end
      end
      ST_SUM: begin
        if (rxValid) begin
          next_state = sumPass ? ST_ENA : ST_CMD;
        end
      end
      ST_ENA: begin
        if (rxValid) begin
          next_state = (!rxErrUart && enableMatch) ? ST_ERASE : ST_CMD;
        end
      end
      ST_ERASE: begin
        if (eraseDone) begin
          next_state = ST_CMD;
        end
      end
      default: begin
        next_state = ST_CMD;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_CMD;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Password and checksum tracking
  // ----------------------------------------
  // Index, mismatch flag and error history
  always_comb begin
    next_pwdIndex = pwdIndex;
    next_pwdErr = pwdErr;
    next_rxErrSeen = rxErrSeen;
    next_sumClear = 1'b0;
    case (state)
      ST_CMD: begin
        // Fresh session on every command byte
        if (rxValid) begin
          next_pwdIndex = 4'h0;
          next_pwdErr = 1'b0;
          next_rxErrSeen = 1'b0;
          next_sumClear = 1'b1;
        end
      end
      ST_PWD: begin
        if (rxValid) begin
          next_rxErrSeen = sumErrs;
          if (pwdSync && (rxData != pwdStored)) begin
            next_pwdErr = 1'b1;
          end
          // Index stops at the last byte
          if (!pwdLast) begin
            next_pwdIndex = pwdIndex + 4'h1;
          end
        end
      end
      default: begin
        // Hold outside the password phase
        next_pwdIndex = pwdIndex;
      end
    endcase
  end

  // Password tracking registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pwdIndex <= 4'h0;
      pwdErr <= 1'b0;
      rxErrSeen <= 1'b0;
      sumClear <= 1'b0;
    end else begin
      pwdIndex <= next_pwdIndex;
      pwdErr <= next_pwdErr;
      rxErrSeen <= next_rxErrSeen;
      sumClear <= next_sumClear;
    end
  end

  // ----------------------------------------
  // Answer bytes and erase start
  // ----------------------------------------
  // Answer code for each non-password byte and for erase end
  always_comb begin
    next_txValid = 1'b0;
    next_txData = txData;
    next_eraseStart = 1'b0;
    next_lastNibble = lastNibble;
    case (state)
      ST_CMD: begin
        if (rxValid) begin
          next_txValid = 1'b1;
          if (rxErrUart) begin
            next_txData = {lastNibble, `NIB_COMM_ERR};
          end else if (cmdMatch) begin
            next_txData = rxData;
            next_lastNibble = rxData[7:4];
          end else begin
            next_txData = {lastNibble, `NIB_CMD_ERR};
            next_lastNibble = rxData[7:4];
          end
        end
      end
      ST_SUM: begin
        if (rxValid) begin
          next_txValid = 1'b1;
          if (!pwdSync) begin
            next_txData = `ACK_NORMAL;
          end else if (sumErrs) begin
            next_txData = `ACK_COMM_ERR;
          end else if (rxData != sumCalc) begin
            next_txData = `ACK_ABNORMAL;
          end else if (pwdErr) begin
            next_txData = `ACK_ABNORMAL;
          end else begin
            next_txData = `ACK_NORMAL;
          end
        end
      end
      ST_ENA: begin
        if (rxValid) begin
          next_txValid = 1'b1;
          if (rxErrUart) begin
            next_txData = `ACK_ENABLE_COMM_ERR;
          end else if (enableMatch) begin
            next_txData = rxData;
            next_eraseStart = 1'b1;
          end else begin
            next_txData = {lastNibble, `NIB_CMD_ERR};
          end
        end
      end
      ST_ERASE: begin
        if (eraseDone) begin
          next_txValid = 1'b1;
          next_txData = eraseFail ? `ACK_ERASE_FAIL : `ACK_ERASE_DONE;
        end
      end
      default: begin
        // Password bytes get no answer
        next_txValid = 1'b0;
      end
    endcase
  end

  // Answer registers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lastNibble <= 4'h0;
      txValid <= 1'b0;
      txData <= 8'h00;
      eraseStart <= 1'b0;
    end else begin
      lastNibble <= next_lastNibble;
      txValid <= next_txValid;
      txData <= next_txData;
      eraseStart <= next_eraseStart;
    end
  end

endmodule

// ---- test/boot_chip_erase_protocol_properties.sv ----
`timescale 1ns/1ps
module boot_chip_erase_protocol_properties (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic uartMode,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic [3:0] pwdIndex,
  input wire logic sumClear,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic eraseStart,
  input wire logic eraseDone,
  input wire logic eraseFail
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Erase engine outcomes
  sequence s_doneOk; eraseDone && !eraseFail; endsequence
  sequence s_doneBad; eraseDone && eraseFail; endsequence
  // Answer timing and contents, erase start pulse and password index range
  property p_ackCause; txValid |-> $past(rxValid) || $past(eraseDone); endproperty
  property p_startEcho; eraseStart |-> txValid && txData == 8'h54; endproperty
  property p_startCause; eraseStart |-> $past(rxValid) && $past(rxData) == 8'h54; endproperty
  property p_startPulse; eraseStart |=> !eraseStart; endproperty
  property p_doneOk; s_doneOk |=> txValid && txData == 8'h4f; endproperty
  property p_doneBad; s_doneBad |=> txValid && txData == 8'h4c; endproperty
  property p_noSioErr; txValid && txData[3:0] == 4'h8 |-> $past(uartMode, 3); endproperty
  property p_sumClear; sumClear |-> txValid; endproperty
  property p_pwdIndex; pwdIndex <= 4'hb; endproperty
  a_ackCause: assert property (p_ackCause) else $error("answer without cause");
  a_startEcho: assert property (p_startEcho) else $error("start without echo");
  a_startCause: assert property (p_startCause) else $error("start without enable");
  a_startPulse: assert property (p_startPulse) else $error("start too long");
  a_doneOk: assert property (p_doneOk) else $error("bad end code");
  a_doneBad: assert property (p_doneBad) else $error("bad fail code");
  a_noSioErr: assert property (p_noSioErr) else $error("comm error in sio");
  a_sumClear: assert property (p_sumClear) else $error("clear without answer");
  a_pwdIndex: assert property (p_pwdIndex) else $error("index out of range");
endmodule
bind boot_chip_erase_protocol boot_chip_erase_protocol_properties u_chk (.core_clk, .arst_n,
  .uartMode, .rxValid, .rxData, .pwdIndex, .sumClear, .txValid, .txData, .eraseStart,
  .eraseDone, .eraseFail);

// ---- test/boot_flash_model.sv ----
`timescale 1ns/1ps
module boot_flash_model (
  input wire logic core_clk,
  input wire logic [3:0] pwdIndex,
  input wire logic eraseStart,
  input wire logic failNext,
  output logic [7:0] pwdStored,
  output logic eraseDone,
  output logic eraseFail
);
  logic [3:0] cnt = 4'h0;
  assign pwdStored = 8'ha0 + {4'h0, pwdIndex};
  // erase lasts a few cycles, fail flag junk outside done
  // host settles after a result before rechecking
  always @(posedge core_clk) begin
    eraseDone <= (cnt == 4'h1);
    eraseFail <= (cnt == 4'h1) ? failNext : ~eraseFail;
    if (eraseStart) cnt <= 4'h6;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule

// ---- test/boot_chip_erase_protocol_tb_top.sv ----
`timescale 1ns/1ps
module boot_chip_erase_protocol_tb_top;
  logic core_clk = 0, arst_n = 0, uartMode = 1, pwdRequired = 0;
  logic rxValid = 0, rxError = 0, failNext = 0;
  logic [7:0] rxData = 8'h00, sumCalc = 8'h5a, txData, pwdStored;
  logic [3:0] pwdIndex;
  logic sumClear, txValid, eraseStart, eraseDone, eraseFail;
  int miscompares = 0;
  int tests_run = 0;
  // Clock
  always #25 core_clk = ~core_clk;
  boot_chip_erase_protocol uut (.core_clk, .arst_n, .uartMode, .pwdRequired, .rxValid,
    .rxData, .rxError, .pwdIndex, .pwdStored, .sumCalc, .sumClear, .txValid, .txData,
    .eraseStart, .eraseDone, .eraseFail);
  boot_flash_model u_flash (.core_clk, .pwdIndex, .eraseStart, .failNext, .pwdStored,
    .eraseDone, .eraseFail);
  task final_report;
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task sendByte(input logic [7:0] d, input logic e);
    @(negedge core_clk);
    rxValid = 1;
    rxData = d;
    rxError = e;
    @(negedge core_clk);
    rxValid = 0;
  endtask
  task expectAck(input logic [7:0] exp);
    int i;
    tests_run++;
    for (i = 0; i < 20; i++) begin
      if (txValid === 1'b1) break;
      @(negedge core_clk);
    end
    if (txValid !== 1'b1) begin
      $display("ERROR %0t no answer", $time);
      miscompares++;
      final_report;
    end else if (txData !== exp) begin
      $display("ERROR %0t got %h want %h", $time, txData, exp);
      miscompares++;
    end
    @(negedge core_clk);
  endtask
  task setMode(input logic u, input logic p);
    @(negedge core_clk);
    uartMode = u;
    pwdRequired = p;
    repeat (3) @(negedge core_clk);
  endtask
  // Command, twelve password bytes, checksum byte
  task head(input logic [7:0] bad, input int errAt, input logic [7:0] sum);
    int i;
    sendByte(8'h40, 1'b0);
    expectAck(8'h40);
    for (i = 0; i < 12; i++) sendByte((8'ha0 + i[7:0]) ^ bad, i == errAt);
    sendByte(sum, 1'b0);
  endtask
  task scNoPwd;
    setMode(1, 0);
    head(8'hff, 3, 8'h00);
    expectAck(8'h40);
    sendByte(8'h54, 1'b0);
    expectAck(8'h54);
    expectAck(8'h4f);
  endtask
  task scPwdEraseFail;
    setMode(1, 1);
    failNext = 1;
    head(8'h00, 99, 8'h5a);
    expectAck(8'h40);
    sendByte(8'h54, 1'b0);
    expectAck(8'h54);
    expectAck(8'h4c);
    repeat (4000) @(negedge core_clk);
    failNext = 0;
  endtask
  task scChecks;
    head(8'h01, 99, 8'h5a);
    expectAck(8'h41);
    head(8'h01, 99, 8'h00);
    expectAck(8'h41);
    head(8'h01, 5, 8'h00);
    expectAck(8'h48);
  endtask
  task scCmdErr;
    sendByte(8'h40, 1'b1);
    expectAck(8'h48);
    sendByte(8'h07, 1'b0);
    expectAck(8'h41);
  endtask
  task scEnable;
    head(8'h00, 99, 8'h5a);
    expectAck(8'h40);
    sendByte(8'h54, 1'b1);
    expectAck(8'h58);
    head(8'h00, 99, 8'h5a);
    expectAck(8'h40);
    sendByte(8'h55, 1'b0);
    expectAck(8'h41);
  endtask
  task scSio;
    setMode(0, 1);
    sendByte(8'h40, 1'b1);
    expectAck(8'h40);
  endtask
  // Reset, then scenarios
  initial begin
    repeat (5) @(negedge core_clk);
    arst_n = 1;
    scNoPwd;
    scPwdEraseFail;
    scChecks;
    scCmdErr;
    scEnable;
    scSio;
    final_report;
  end
endmodule
